// file: core/acr_pkg.sv
// shared constants for the converter readout link: device end and controller end
// assumes both ends and the link interface are compiled after this package
package acr_pkg;
   // ==========================================================
   // clocking
   localparam int CLK_PERIOD_NS = 10;          // sys_clk period
   localparam int POR_TIME_NS   = 1_000_000;   // power-on reset length, 1 ms
   localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF      = 6;           // sys_clk cycles per half serial clock
   localparam int CONV_CYCLES   = 2000;        // conversion length in sys_clk cycles
   localparam int TMR_W         = 20;          // width of the device phase timer
   // ==========================================================
   // frame layout
   localparam int          WORD_W     = 24;                // bits per transfer
   localparam logic [4:0]  WORD_EDGES = 5'h18;             // rising edges per frame
   localparam logic [4:0]  LAST_FALL  = 5'h17;             // last controller fall index
   localparam logic        EOC_BUSY   = 1'b1;              // flag level while converting
   localparam logic        EOC_DONE   = 1'b0;              // flag level once finished
   localparam logic [23:0] CFG_RESET  = 24'h000000;        // config before first frame
   // ==========================================================
   // device sequencer states
   typedef enum logic [2:0] {
      ST_POR   = 3'h0,
      ST_CONV  = 3'h1,
      ST_SLEEP = 3'h2,
      ST_XFER  = 3'h3,
      ST_EXT   = 3'h4
   } acr_state_t;
endpackage

// file: core/acr_link_if.sv
// link between the converter device end and the controller end
// assumes: the device owns the serial clock; the controller only listens to it,
// except that it may hold the pin low during power-on reset
`timescale 1ns/1ps
interface acr_link_if;
   logic devSckO;     // device clock drive value
   logic devSckOe;    // device drives the clock pin
   logic devPullEn;   // device weak pull-up on the clock pin
   logic hostSckO;    // controller clock drive value
   logic hostSckOe;   // controller drives the clock pin
   logic sck;         // resolved clock pin level
   logic sdo;         // device data out, eoc flag between frames
   logic sdi;         // controller data in to the device

   // ==========================================================
   // pin resolution: a strong driver wins over the pull-up; a pin with neither
   // is modelled as low, like a heavy load the pull-up cannot lift
   assign sck = devSckOe ? devSckO : (hostSckOe ? hostSckO : devPullEn);

   modport dev  (input sck, input sdi, output devSckO, output devSckOe,
                 output devPullEn, output sdo);
   modport host (input sck, input sdo, output sdi, output hostSckO, output hostSckOe);
endinterface

// file: core/acr_host_end.sv
// controller end: receives 24-bit result words and sends 24-bit config words
// assumes the device drives the serial clock; the link logic runs on that clock,
// which stands still high between frames
`timescale 1ns/1ps
module acr_host_end
   import acr_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                reset,
   acr_link_if.host                 lnk,
   input  wire logic [WORD_W-1:0]   cfgWord,
   input  wire logic                cfgLoad,
   input  wire logic                holdSckLow,
   output logic      [WORD_W-1:0]   rxData,
   output logic                     rxValid
);
   // ==========================================================
   // user side: config hold register, request toggle, done synchroniser
   logic [WORD_W-1:0] cfgHold_reg, cfgHold_next;
   logic              reqTgl_reg, reqTgl_next;
   logic [2:0]        doneSync_reg, doneSync_next;
   logic [WORD_W-1:0] rxData_reg, rxData_next;
   logic              rxValid_reg, rxValid_next;
   // link side
   logic [4:0]        rxCnt_reg, rxCnt_next;
   logic [WORD_W-1:0] rxShift_reg, rxShift_next;
   logic [WORD_W-1:0] rxWord_reg, rxWord_next;
   logic              doneTgl_reg, doneTgl_next;
   logic [4:0]        txCnt_reg, txCnt_next;
   logic [WORD_W-1:0] txShift_reg, txShift_next;
   logic [WORD_W-1:0] cfgLink_reg, cfgLink_next;
   logic [1:0]        reqSync_reg, reqSync_next;
   logic              reqSeen_reg, reqSeen_next;
   logic              sdi_reg, sdi_next;

   // no chip select line leaves this end: the link stays three wires
   // holding the pin low through power-on reset steers the device to external mode
   assign lnk.hostSckO  = 1'b0;
   assign lnk.hostSckOe = holdSckLow;
   assign lnk.sdi       = sdi_reg;
   assign rxData        = rxData_reg;
   assign rxValid       = rxValid_reg;

   // ==========================================================
   // user side next values; the word is taken only after the toggle crossed,
   // by then it has been stable in the user domain for at least two link clock falls
   always_comb begin
      cfgHold_next  = cfgLoad ? cfgWord : cfgHold_reg;
      reqTgl_next   = cfgLoad ? ~reqTgl_reg : reqTgl_reg;
      doneSync_next = {doneSync_reg[1:0], doneTgl_reg};
      rxValid_next  = doneSync_reg[2] ^ doneSync_reg[1];
      rxData_next   = rxValid_next ? rxWord_reg : rxData_reg;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cfgHold_reg  <= CFG_RESET;
         reqTgl_reg   <= 1'b0;
         doneSync_reg <= 3'h0;
         rxData_reg   <= '0;
         rxValid_reg  <= 1'b0;
      end else begin
         cfgHold_reg  <= cfgHold_next;
         reqTgl_reg   <= reqTgl_next;
         doneSync_reg <= doneSync_next;
         rxData_reg   <= rxData_next;
         rxValid_reg  <= rxValid_next;
      end
   end

   // ==========================================================
   // capture on rising clock edges; the first one carries the eoc flag
   always_comb begin
      rxShift_next = {rxShift_reg[WORD_W-2:0], lnk.sdo};
      rxCnt_next   = rxCnt_reg + 5'h01;
      rxWord_next  = rxWord_reg;
      doneTgl_next = doneTgl_reg;
      if (rxCnt_reg == WORD_EDGES - 5'h01) begin
         rxCnt_next   = 5'h00;
         rxWord_next  = rxShift_next;
         doneTgl_next = ~doneTgl_reg;   // word stays put until the next frame ends
      end
   end

   always_ff @(posedge lnk.sck or posedge reset) begin
      if (reset) begin
         rxCnt_reg   <= 5'h00;
         rxShift_reg <= '0;
         rxWord_reg  <= '0;
         doneTgl_reg <= 1'b0;
      end else begin
         rxCnt_reg   <= rxCnt_next;
         rxShift_reg <= rxShift_next;
         rxWord_reg  <= rxWord_next;
         doneTgl_reg <= doneTgl_next;
      end
   end

   // ==========================================================
   // drive data-in on falling edges, so each bit is settled a half period before
   // the device samples it; fall 0 is the completion edge of the frame
   always_comb begin
      reqSync_next = {reqSync_reg[0], reqTgl_reg};
      reqSeen_next = reqSync_reg[1];
      cfgLink_next = (reqSync_reg[1] != reqSeen_reg) ? cfgHold_reg : cfgLink_reg;
      txCnt_next   = (txCnt_reg == LAST_FALL) ? 5'h00 : txCnt_reg + 5'h01;
      if (txCnt_reg == 5'h00) begin
         sdi_next     = cfgLink_reg[WORD_W-1];
         txShift_next = {cfgLink_reg[WORD_W-2:0], 1'b0};
      end else begin
         sdi_next     = txShift_reg[WORD_W-1];
         txShift_next = {txShift_reg[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(negedge lnk.sck or posedge reset) begin
      if (reset) begin
         reqSync_reg <= 2'h0;
         reqSeen_reg <= 1'b0;
         cfgLink_reg <= CFG_RESET;
         txCnt_reg   <= 5'h00;
         txShift_reg <= '0;
         sdi_reg     <= 1'b0;
      end else begin
         reqSync_reg <= reqSync_next;
         reqSeen_reg <= reqSeen_next;
         cfgLink_reg <= cfgLink_next;
         txCnt_reg   <= txCnt_next;
         txShift_reg <= txShift_next;
         sdi_reg     <= sdi_next;
      end
   end
endmodule

// file: core/acr_dev_end.sv
// device end: converter readout sequencer, internal serial clock, 3-wire,
// continuous conversion
// assumes: sys_clk stands for the internal oscillator, reset for power-on reset,
// sampleWord is held by the converter core and is caught at each conversion end
//
// Behaviour
// - mode picked once, at power-on reset end
// - power-on reset lasts about one millisecond
// - weak clock pull-up on during reset
// - clock pin held low selects external mode
// - chip select may stay low always
// - converting: clock and data out high
// - completion: both low, enter sleep
// - sleep half clock period, then transfer
// - transfer is exactly 24 rising edges
// - data-in sampled on every rising edge
// - data out updated on falling edges
// - device drives clock; controller times by it
// - controller latches flag on first rise
// - after 24th rise: data high, convert
// - clock stays high through whole conversion
`timescale 1ns/1ps
module acr_dev_end
   import acr_pkg::*;
#(
   parameter int POR_LEN  = POR_CYCLES,
   parameter int CONV_LEN = CONV_CYCLES,
   parameter int HALF_LEN = SCK_HALF
)
(
   input  wire logic                sys_clk,
   input  wire logic                reset,
   acr_link_if.dev                  lnk,
   input  wire logic [WORD_W-2:0]   sampleWord,
   output logic      [WORD_W-1:0]   cfgData,
   output logic                     cfgValid,
   output logic                     internalMode,
   output logic                     convBusy
);
   // ==========================================================
   // elaboration checks: the data-in synchroniser needs room inside a half period
   if (HALF_LEN < 3) begin : g_half_chk
      $error("serial clock half period must be at least 3 cycles");
   end
   if (POR_LEN < 1 || POR_LEN >= (1 << TMR_W) || CONV_LEN < 1 ||
       CONV_LEN >= (1 << TMR_W)) begin : g_len_chk
      $error("reset or conversion length does not fit the timer");
   end

   localparam logic [TMR_W-1:0] POR_LAST  = TMR_W'(POR_LEN - 1);
   localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_LEN - 1);
   localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF_LEN - 1);
   localparam logic [TMR_W-1:0] TMR_ONE   = TMR_W'(1);

   // ==========================================================
   // state
   acr_state_t        state_reg, state_next;
   logic [TMR_W-1:0]  tmr_reg, tmr_next;
   logic [4:0]        edges_reg, edges_next;
   logic [WORD_W-1:0] txShift_reg, txShift_next;
   logic [WORD_W-1:0] rxShift_reg, rxShift_next;
   logic [WORD_W-1:0] cfg_reg, cfg_next;
   logic              cfgValid_reg, cfgValid_next;
   logic              mode_reg, mode_next;
   logic              sckO_reg, sckO_next;
   logic              sckOe_reg, sckOe_next;
   logic              pullEn_reg, pullEn_next;
   logic              sdo_reg, sdo_next;
   // pin synchronisers: stage one is read only by stage two
   logic              sckMeta_reg, sckSync_reg;
   logic              sdiMeta_reg, sdiSync_reg;

   assign lnk.devSckO   = sckO_reg;
   assign lnk.devSckOe  = sckOe_reg;
   assign lnk.devPullEn = pullEn_reg;
   assign lnk.sdo       = sdo_reg;
   assign cfgData       = cfg_reg;
   assign cfgValid      = cfgValid_reg;
   assign internalMode  = mode_reg;
   assign convBusy      = (state_reg == ST_CONV);

   // ==========================================================
   // two-stage synchronisers for the clock pin strap and the data-in pin
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sckMeta_reg <= 1'b0;
         sckSync_reg <= 1'b0;
         sdiMeta_reg <= 1'b0;
         sdiSync_reg <= 1'b0;
      end else begin
         sckMeta_reg <= lnk.sck;
         sckSync_reg <= sckMeta_reg;
         sdiMeta_reg <= lnk.sdi;
         sdiSync_reg <= sdiMeta_reg;
      end
   end

   // ==========================================================
   // sequencer next values
   always_comb begin
      state_next    = state_reg;
      tmr_next      = tmr_reg + TMR_ONE;
      edges_next    = edges_reg;
      txShift_next  = txShift_reg;
      rxShift_next  = rxShift_reg;
      cfg_next      = cfg_reg;
      cfgValid_next = 1'b0;
      mode_next     = mode_reg;
      sckO_next     = sckO_reg;
      sckOe_next    = sckOe_reg;
      pullEn_next   = 1'b0;
      sdo_next      = sdo_reg;
      case (state_reg)
         ST_POR: begin
            // pin left to the pull-up so an undriven clock line reads high
            pullEn_next = 1'b1;
            sckOe_next  = 1'b0;
            sdo_next    = EOC_BUSY;
            if (tmr_reg == POR_LAST) begin
               tmr_next    = '0;
               pullEn_next = 1'b0;
               // the strap is caught here by the clock, never by the reset itself
               mode_next   = sckSync_reg;
               if (sckSync_reg) begin
                  state_next  = ST_CONV;
                  sckOe_next  = 1'b1;
                  sckO_next   = 1'b1;
                  // pull-up kept one more cycle so the pin never floats low mid hand-over
                  pullEn_next = 1'b1;
               end else begin
                  state_next = ST_EXT;
               end
            end
         end
         ST_CONV: begin
            // no clock activity while the modulator runs
            sckO_next = 1'b1;
            sdo_next  = EOC_BUSY;
            if (tmr_reg == CONV_LAST) begin
               tmr_next     = '0;
               state_next   = ST_SLEEP;
               sckO_next    = 1'b0;
               sdo_next     = EOC_DONE;
               txShift_next = {EOC_DONE, sampleWord};
            end
         end
         ST_SLEEP: begin
            // no external request is awaited; the timer alone starts the frame
            if (tmr_reg == HALF_LAST) begin
               tmr_next     = '0;
               state_next   = ST_XFER;
               sckO_next    = 1'b1;
               rxShift_next = {rxShift_reg[WORD_W-2:0], sdiSync_reg};
               edges_next   = 5'h01;
            end
         end
         ST_XFER: begin
            if (tmr_reg == HALF_LAST) begin
               tmr_next = '0;
               if (sckO_reg && edges_reg == WORD_EDGES) begin
                  // frame over: new conversion, new config handed to the core
                  state_next    = ST_CONV;
                  sdo_next      = EOC_BUSY;
                  cfg_next      = rxShift_reg;
                  cfgValid_next = 1'b1;
               end else if (sckO_reg) begin
                  sckO_next    = 1'b0;
                  sdo_next     = txShift_reg[WORD_W-2];
                  txShift_next = {txShift_reg[WORD_W-2:0], 1'b1};
               end else begin
                  // synced data-in lags the pin by two cycles, well inside a half
                  sckO_next    = 1'b1;
                  rxShift_next = {rxShift_reg[WORD_W-2:0], sdiSync_reg};
                  edges_next   = edges_reg + 5'h01;
               end
            end
         end
         ST_EXT: begin
            // externally clocked operation is outside this block: idle, pin free
            tmr_next   = tmr_reg;
            sckOe_next = 1'b0;
            sdo_next   = EOC_BUSY;
         end
         default: begin
            state_next = ST_POR;
            tmr_next   = '0;
         end
      endcase
   end

   // ==========================================================
   // sequencer registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg    <= ST_POR;
         tmr_reg      <= '0;
         edges_reg    <= 5'h00;
         txShift_reg  <= '0;
         rxShift_reg  <= '0;
         cfg_reg      <= CFG_RESET;
         cfgValid_reg <= 1'b0;
         mode_reg     <= 1'b0;
         sckO_reg     <= 1'b1;
         sckOe_reg    <= 1'b0;
         pullEn_reg   <= 1'b1;
         sdo_reg      <= EOC_BUSY;
      end else begin
         state_reg    <= state_next;
         tmr_reg      <= tmr_next;
         edges_reg    <= edges_next;
         txShift_reg  <= txShift_next;
         rxShift_reg  <= rxShift_next;
         cfg_reg      <= cfg_next;
         cfgValid_reg <= cfgValid_next;
         mode_reg     <= mode_next;
         sckO_reg     <= sckO_next;
         sckOe_reg    <= sckOe_next;
         pullEn_reg   <= pullEn_next;
         sdo_reg      <= sdo_next;
      end
   end

   // chip select is not a port: this mode works with it tied low
endmodule

// file: testbench/acr_link_sva.sv
// checker for the converter readout link, watching the shared wires only
// assumes the bench runs the device with HALF_LEN 6, so literal 6 below is one half clock
`timescale 1ns/1ps
module acr_link_sva #(
   parameter int POR_LEN  = 50,
   parameter int CONV_LEN = 40
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic devSckOe,
   input wire logic devPullEn,
   input wire logic sck,
   input wire logic sdo
);
   localparam int CONV_M2 = CONV_LEN - 2;
   logic [4:0]  riseCnt_reg;
   logic [4:0]  riseCnt_next;
   logic [19:0] porCnt_reg;
   logic [19:0] porCnt_next;
   logic        sckQ_reg;
   // ==========================================================
   // helper counters: rises wrap every frame, so a fall at count 0 is a completion
   always_comb begin
      riseCnt_next = riseCnt_reg;
      porCnt_next  = devPullEn ? porCnt_reg + 20'h00001 : porCnt_reg;
      if (sck && !sckQ_reg && devSckOe) begin
         riseCnt_next = (riseCnt_reg == 5'h17) ? 5'h00 : riseCnt_reg + 5'h01;
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         riseCnt_reg <= 5'h00;
         porCnt_reg  <= 20'h00000;
         sckQ_reg    <= 1'b1;
      end else begin
         riseCnt_reg <= riseCnt_next;
         porCnt_reg  <= porCnt_next;
         sckQ_reg    <= sck;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // assertions
   pull_reset_a: assert property ($fell(reset) |-> $past(devPullEn) && !$past(devSckOe))
      else $error("clock pull-up not on during reset");
   mode_pick_a: assert property ($fell(devPullEn) |-> devSckOe == $past(sck, 2)
      && porCnt_reg inside {[POR_LEN-2:POR_LEN+2]}) else $error("mode choice wrong");
   ext_quiet_a: assert property (!devPullEn && !devSckOe |=> !devSckOe && sdo)
      else $error("external mode drove a wire");
   sck_owner_a: assert property ($rose(sck) |-> devSckOe)
      else $error("clock rose without device drive");
   done_low_a: assert property ($fell(sck) && riseCnt_reg == 5'h00 |-> !sdo)
      else $error("completion without data low");
   sleep_half_a: assert property ($fell(sck) && riseCnt_reg == 5'h00 |-> (!sck)[*6] ##1 sck)
      else $error("sleep not one half period");
   fall_update_a: assert property ($changed(sdo) |-> $fell(sck)
      || (sck && sdo && riseCnt_reg == 5'h00)) else $error("data moved off a falling edge");
   frame_end_a: assert property ($rose(sck) && riseCnt_reg == 5'h17
      |-> sck[*6] ##1 (sck && sdo)) else $error("frame end wrong");
   conv_high_a: assert property ($rose(sck) && riseCnt_reg == 5'h17 |-> ##7
      ((sck && sdo) throughout ##[CONV_M2:CONV_M2] 1'b1)) else $error("clock moved in conversion");
   ext_c: cover property ($fell(devPullEn) && !devSckOe);
   done_c: cover property ($fell(sck) && riseCnt_reg == 5'h00);
   end_c: cover property ($rose(sck) && riseCnt_reg == 5'h17);
endmodule

// file: testbench/adc_internal_clock_continuous_readout_tb.sv
// self-checking bench: device end and controller end joined by one link
// assumes short power-on and conversion counts; the device makes the serial clock
`timescale 1ns/1ps
module adc_internal_clock_continuous_readout_tb;
   import acr_pkg::*;
   localparam int TB_POR  = 50;
   localparam int TB_CONV = 40;
   localparam int TB_HALF = 6;
   logic                sys_clk, reset, cfgLoad, holdSckLow, cfgValid, internalMode;
   logic                convBusy, rxValid;
   logic [WORD_W-2:0]   sampleWord;
   logic [WORD_W-1:0]   cfgData, cfgWord, rxData;
   int                  bad_count, checks, gap;
   acr_link_if lnk ();
   acr_dev_end #(.POR_LEN(TB_POR), .CONV_LEN(TB_CONV), .HALF_LEN(TB_HALF)) u_acr_dev_end (
      .sys_clk(sys_clk), .reset(reset), .lnk(lnk), .sampleWord(sampleWord), .cfgData(cfgData),
      .cfgValid(cfgValid), .internalMode(internalMode), .convBusy(convBusy));
   acr_host_end u_acr_host_end (.sys_clk(sys_clk), .reset(reset), .lnk(lnk), .cfgWord(cfgWord),
      .cfgLoad(cfgLoad), .holdSckLow(holdSckLow), .rxData(rxData), .rxValid(rxValid));
   acr_link_sva #(.POR_LEN(TB_POR), .CONV_LEN(TB_CONV)) u_acr_link_sva (.sys_clk(sys_clk),
      .reset(reset), .devSckOe(lnk.devSckOe), .devPullEn(lnk.devPullEn), .sck(lnk.sck),
      .sdo(lnk.sdo));
   // ==========================================================
   // clock and common tasks
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // inputs move 1 ns after the edge so no race with the design's sampling
   task automatic do_reset(input logic hold);
      @(posedge sys_clk);
      #1 holdSckLow = hold;
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (TB_POR + 10) @(posedge sys_clk);
      #1;
   endtask
   // bounded wait for a received word; gap returns the cycles spent
   task automatic wait_rx();
      gap = 0;
      do begin
         @(posedge sys_clk);
         #1 gap++;
      end while (rxValid !== 1'b1 && gap < 1000);
      check("rxValid seen", 24'h000001, {23'h0, rxValid});
   endtask
   task automatic wait_cfg(input logic [23:0] exp);
      int n = 0;
      while (!(cfgValid === 1'b1 && cfgData === exp) && n < 1200) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("cfgData", exp, cfgData);
   endtask
   task automatic send_cfg(input logic [23:0] w);
      @(posedge sys_clk);
      #1 cfgWord = w;
      cfgLoad = 1'b1;
      @(posedge sys_clk);
      #1 cfgLoad = 1'b0;
   endtask
   // ==========================================================
   // scenarios
   // clock pin held low through reset: device must stay silent
   task automatic test_ext_mode();
      int frames = 0;
      do_reset(1'b1);
      check("internalMode ext", 24'h000000, {23'h0, internalMode});
      holdSckLow = 1'b0;
      repeat (3 * TB_CONV) begin
         @(posedge sys_clk);
         #1;
         if (rxValid === 1'b1) frames++;
      end
      check("frames in ext mode", 24'h000000, frames[23:0]);
      check("sdo in ext mode", 24'h000001, {23'h0, lnk.sdo});
   endtask
   // free-running frames: word order, flag, spacing and config capture
   task automatic test_frames();
      do_reset(1'b0);
      check("internalMode int", 24'h000001, {23'h0, internalMode});
      send_cfg(24'hA5C3F0);
      wait_rx();
      check("rxData first", {EOC_DONE, 23'h2A5C3C}, rxData);
      check("convBusy in frame", 24'h000000, {23'h0, convBusy});
      sampleWord = 23'h55A3C3;
      wait_rx();
      check("frame period", 24'(TB_CONV + 48 * TB_HALF), gap[23:0]);
      check("rxData second", {EOC_DONE, 23'h55A3C3}, rxData);
      wait_cfg(24'hA5C3F0);
      check("convBusy in conversion", 24'h000001, {23'h0, convBusy});
      send_cfg(24'hFFFFFF);
      wait_cfg(24'hFFFFFF);
      send_cfg(24'h000001);
      wait_cfg(24'h000001);
   endtask
   // reset in mid-transfer, then the link must frame cleanly again
   task automatic test_mid_reset();
      wait_rx();
      repeat (TB_CONV + 60) @(posedge sys_clk);
      #1 sampleWord = 23'h7FFFFE;
      do_reset(1'b0);
      wait_rx();
      check("rxData after reset", {EOC_DONE, 23'h7FFFFE}, rxData);
   endtask
   // ==========================================================
   // run control
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      conclude();
   end
   initial begin
      reset      = 1'b1;
      cfgLoad    = 1'b0;
      holdSckLow = 1'b0;
      cfgWord    = 24'h000000;
      sampleWord = 23'h2A5C3C;
      bad_count  = 0;
      checks     = 0;
      test_ext_mode();
      test_frames();
      test_mid_reset();
      conclude();
   end
endmodule
